// *** common/csil_pkg.sv ***
// Shared constants for the core sense and inhibit loop.
`default_nettype none
package csil_pkg;
    // Number of 8K increments that share the select lines.
    localparam int CSIL_NUM_INCR = 4;
    // Number of half stacks (A and B) inside one increment.
    localparam int CSIL_NUM_HALF = 2;
    // Width of the memory data word.
    localparam int CSIL_DATA_W = 16;
    // Width of one byte group, which shares a strobe and an inhibit pulse.
    localparam int CSIL_BYTE_W = 8;
    // Index of the low byte group and of the high byte group.
    localparam int CSIL_LOW_GRP = 0;
    localparam int CSIL_HIGH_GRP = 1;
    // Value of every control flip-flop after reset.
    localparam logic CSIL_RST_BIT = 1'h0;
    // Level driven onto a wire-OR bit line while the output is enabled.
    localparam logic CSIL_PULL_LOW = 1'h0;
    // Cycles from an input edge to the derived strobe or pulse.
    localparam int CSIL_STROBE_LAT = 1;
    // Cycles from an input edge to a bit line or inhibit output.
    localparam int CSIL_BIT_LAT = 2;
endpackage
`default_nettype wire

// *** design/csil_byte_slice.sv ***
// One byte group of sense latches and inhibit drivers.
`timescale 1ns/1ps
`default_nettype none
module csil_byte_slice #(
    parameter int WIDTH = csil_pkg::CSIL_BYTE_W
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic strobe,
    input wire logic pulse,
    input wire logic [WIDTH-1:0] sense_one,
    input wire logic [WIDTH-1:0] line_n_i,
    output logic [WIDTH-1:0] line_oe,
    output logic [WIDTH-1:0] read_one,
    output logic [WIDTH-1:0] inhibit
);
    import csil_pkg::*;

    // A strobed one pulls the shared data bit line low.
    logic [WIDTH-1:0] next_line_oe;
    // A bit that read one this cycle is marked, and keeps the mark only while the pulse is on.
    logic [WIDTH-1:0] next_read_one;
    // Inhibit fires only for a zero on the line during the pulse.
    logic [WIDTH-1:0] next_inhibit;
    // Set for the latched marker wins over its clear.
    logic [WIDTH-1:0] set_one;

    assign set_one = strobe ? sense_one : '0;
    assign next_line_oe = set_one;
    assign next_read_one = set_one | (pulse ? read_one : '0);
    // A zero level on the line ANDed with the pulse turns inhibit on; a read
    // one keeps it off even if the register has not settled the line yet.
    assign next_inhibit = pulse ? (line_n_i & ~read_one) : '0;

    // The latches are plain registers so every output comes from a flop.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            line_oe <= '0;
            read_one <= '0;
            inhibit <= '0;
        end else begin
            line_oe <= next_line_oe;
            read_one <= next_read_one;
            inhibit <= next_inhibit;
        end
    end
endmodule
`default_nettype wire

// *** design/csil_top.sv ***
// Sense and inhibit control loop for one 4K half stack of a 16-bit word.
`timescale 1ns/1ps
`default_nettype none
module csil_top #(
    // Which increment select line addresses this increment.
    parameter int INCR_INDEX = 0,
    // Which half stack this instance serves: 0 for A, 1 for B.
    parameter int HALF_INDEX = 0
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [csil_pkg::CSIL_NUM_INCR-1:0] increment_select_n,
    input wire logic [csil_pkg::CSIL_NUM_HALF-1:0] half_stack_enable,
    input wire logic sense_strobe_in_n,
    input wire logic inhibit_timing_in_n,
    input wire logic write_cycle_flag,
    input wire logic [csil_pkg::CSIL_DATA_W-1:0] sense_line_pair,
    input wire logic [csil_pkg::CSIL_DATA_W-1:0] data_bit_line_n_i,
    output logic [csil_pkg::CSIL_DATA_W-1:0] data_bit_line_n_o,
    output logic [csil_pkg::CSIL_DATA_W-1:0] data_bit_line_n_oe,
    output logic sense_strobe_low_byte,
    output logic sense_strobe_high_byte,
    output logic inhibit_pulse_low_byte,
    output logic inhibit_pulse_high_byte,
    output logic [csil_pkg::CSIL_DATA_W-1:0] inhibit_current_out
);
    import csil_pkg::*;

    // True when exactly one bit of the vector is set.
    function automatic logic one_hot(input logic [CSIL_NUM_INCR-1:0] v);
        logic [CSIL_NUM_INCR-1:0] low;
        low = v & (v - 1'b1);
        return (v != '0) && (low == '0);
    endfunction

    // Asserted select lines, turned active high for decoding.
    wire [CSIL_NUM_INCR-1:0] incr_active = ~increment_select_n;
    // This increment is addressed only by a clean one-hot select.
    wire incr_sel = one_hot(incr_active) && incr_active[INCR_INDEX];
    // Within the increment, only the own half stack may run.
    wire half_sel = half_stack_enable[HALF_INDEX];
    // The whole stack is idle unless both selects agree.
    wire stack_sel = incr_sel && half_sel;
    // The controller already holds the strobe off in a write cycle, so
    // no extra gating on write_cycle_flag is needed here.
    wire next_strobe = stack_sel && !sense_strobe_in_n;
    // Inhibit timing is the write sink strobe, so it lines up with the
    // write current; we only gate it with the selection.
    wire next_pulse = stack_sel && !inhibit_timing_in_n;

    // Per-group strobe and pulse fan out to the two byte slices.
    logic [1:0] grp_strobe;
    logic [1:0] grp_pulse;
    assign grp_strobe = {sense_strobe_high_byte, sense_strobe_low_byte};
    assign grp_pulse = {inhibit_pulse_high_byte, inhibit_pulse_low_byte};

    // Latched read-one markers from both slices.
    logic [CSIL_DATA_W-1:0] read_one;

    // Two strobes and two pulses are kept as separate flops so that each
    // byte group can be loaded by its own driver, as on the card.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sense_strobe_low_byte <= CSIL_RST_BIT;
            sense_strobe_high_byte <= CSIL_RST_BIT;
            inhibit_pulse_low_byte <= CSIL_RST_BIT;
            inhibit_pulse_high_byte <= CSIL_RST_BIT;
        end else begin
            sense_strobe_low_byte <= next_strobe;
            sense_strobe_high_byte <= next_strobe;
            inhibit_pulse_low_byte <= next_pulse;
            inhibit_pulse_high_byte <= next_pulse;
        end
    end

    // The open-collector lines only ever pull low; the level register is
    // constant so the output still comes from a flop.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            data_bit_line_n_o <= '0;
        end else begin
            data_bit_line_n_o <= {CSIL_DATA_W{CSIL_PULL_LOW}};
        end
    end

    // Both byte groups use the same slice; only the strobe and pulse
    // differ between them.
    for (genvar g = 0; g < 2; g++) begin : g_grp
        csil_byte_slice #(
            .WIDTH(CSIL_BYTE_W)
        ) u_slice (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .strobe(grp_strobe[g]),
            .pulse(grp_pulse[g]),
            .sense_one(sense_line_pair[g*CSIL_BYTE_W +: CSIL_BYTE_W]),
            .line_n_i(data_bit_line_n_i[g*CSIL_BYTE_W +: CSIL_BYTE_W]),
            .line_oe(data_bit_line_n_oe[g*CSIL_BYTE_W +: CSIL_BYTE_W]),
            .read_one(read_one[g*CSIL_BYTE_W +: CSIL_BYTE_W]),
            .inhibit(inhibit_current_out[g*CSIL_BYTE_W +: CSIL_BYTE_W])
        );
    end

    // Checks on the loop, all in the single clock domain.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    // An unselected stack derives no strobe and no pulse.
    property p_idle;
        !stack_sel |=> !sense_strobe_low_byte && !sense_strobe_high_byte
            && !inhibit_pulse_low_byte && !inhibit_pulse_high_byte;
    endproperty
    a_idle: assert property (p_idle)
        else $error("Unselected stack produced a strobe or pulse.");

    // Two selects at once must not enable this increment.
    property p_multi_sel;
        !one_hot(incr_active) |=> !sense_strobe_high_byte;
    endproperty
    a_multi_sel: assert property (p_multi_sel)
        else $error("Strobe despite ambiguous increment select.");

    // The other half stack's enable never drives this one.
    property p_half;
        !half_stack_enable[HALF_INDEX] |=> !inhibit_pulse_high_byte;
    endproperty
    a_half: assert property (p_half)
        else $error("Pulse while own half stack not enabled.");

    // A selected strobe yields both byte strobes one cycle later.
    property p_strobe;
        stack_sel && !sense_strobe_in_n
            |=> sense_strobe_low_byte && sense_strobe_high_byte;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("Byte strobes missing after sense strobe.");

    // A selected inhibit timing yields both byte pulses.
    property p_pulse;
        stack_sel && !inhibit_timing_in_n
            |=> inhibit_pulse_low_byte && inhibit_pulse_high_byte;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("Byte pulses missing after inhibit timing.");

    // A strobed one on the top bit pulls its line low next cycle.
    property p_sense_one;
        sense_strobe_high_byte && sense_line_pair[15]
            |=> data_bit_line_n_oe[15] && !data_bit_line_n_o[15];
    endproperty
    a_sense_one: assert property (p_sense_one)
        else $error("Sensed one did not pull the bit line low.");

    // The line is never pulled without a strobe in the cycle before.
    property p_oe_cause;
        data_bit_line_n_oe[0] |-> $past(sense_strobe_low_byte);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("Bit line pulled without a strobe.");

    // A bit that read one keeps its inhibit off on the next cycle.
    property p_read_one_off;
        data_bit_line_n_oe[15] |=> !inhibit_current_out[15];
    endproperty
    a_read_one_off: assert property (p_read_one_off)
        else $error("Inhibit on for a bit that read one.");

    // A zero line with the pulse fires inhibit, unless read one is marked.
    property p_zero_fires;
        inhibit_pulse_high_byte && data_bit_line_n_i[15] && !read_one[15]
            |=> inhibit_current_out[15];
    endproperty
    a_zero_fires: assert property (p_zero_fires)
        else $error("Inhibit did not fire for a zero bit.");

    // A one held by the data register keeps inhibit off in write.
    property p_write_one;
        data_bit_line_n_i[3] == 1'b0 |=> !inhibit_current_out[3];
    endproperty
    a_write_one: assert property (p_write_one)
        else $error("Inhibit on while data register holds one.");

    // Inhibit is only ever the product of its own group's pulse.
    property p_inh_cause;
        inhibit_current_out[0] |-> $past(inhibit_pulse_low_byte)
            && $past(data_bit_line_n_i[0]);
    endproperty
    a_inh_cause: assert property (p_inh_cause)
        else $error("Inhibit without pulse and zero level.");

    // Main scenarios: a read of one, an inhibit, and a write cycle pulse.
    c_read_one: cover property (data_bit_line_n_oe[15]);
    c_inhibit: cover property (inhibit_current_out[15]);
    c_write: cover property (write_cycle_flag && inhibit_pulse_low_byte);
endmodule
`default_nettype wire

// *** sim/csil_mem_model.sv ***
// Bench model of the timing controller and the memory data register.
`timescale 1ns/1ps
`default_nettype none
module csil_mem_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic go,
    input wire logic wr,
    input wire logic slow,
    input wire logic [15:0] wdata,
    input wire logic [15:0] line_oe,
    output logic sense_strobe_in_n,
    output logic inhibit_timing_in_n,
    output logic write_cycle_flag,
    output logic [15:0] line_n,
    output logic [15:0] word_n,
    output logic busy
);
    int step; // Position inside the current memory cycle.
    int gap; // Extra restore delay when answering slowly.
    logic g; // Start request seen at the edge.
    logic [15:0] oe_q; // Pull-down enables seen at the edge.
    // Open-collector lines: any enabled driver pulls the line low.
    assign line_n = word_n & ~line_oe;
    // One process owns every output except line_n, so each has a single driver; it sets
    // the idle levels first, then takes inputs at the edge and moves its
    // outputs just after it.
    initial begin
        {sense_strobe_in_n, inhibit_timing_in_n} = 2'h3;
        {write_cycle_flag, busy} = 2'h0;
        step = 0;
        gap = 0;
        word_n = 16'hFFFF;
        forever begin
            @(posedge clk_sys);
            g = go;
            oe_q = line_oe;
            #1;
            if (sys_rst) begin
                {sense_strobe_in_n, inhibit_timing_in_n} = 2'h3;
                {write_cycle_flag, busy, step} = '0;
            end else if (step == 0) begin
                if (g) begin
                    // A read clears the register first; a write loads it.
                    step = 1;
                    busy = 1'h1;
                    write_cycle_flag = wr;
                    word_n = wr ? ~wdata : 16'hFFFF;
                    gap = slow ? 3 : 0;
                end
            end else begin
                word_n = word_n & ~oe_q;
                step = step + 1;
                // A write cycle issues no sense strobe at all.
                sense_strobe_in_n = !((step == 2 || step == 3) &&
                    !write_cycle_flag);
                // Inhibit timing doubles as the write sink strobe.
                inhibit_timing_in_n = !(step >= 6 + gap &&
                    step <= 8 + gap);
                if (step == 10 + gap) begin
                    {write_cycle_flag, busy, step} = '0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/csil_top_tb_top.sv ***
// Self-checking bench for the sense and inhibit loop.
`timescale 1ns/1ps
`default_nettype none
module csil_top_tb_top;
    import csil_pkg::*;
    localparam int INCR = 2; // Off-zero indices catch index slips.
    localparam int HALF = 1;
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    logic [3:0] increment_select_n = 4'hF;
    logic [1:0] half_stack_enable = 2'h0;
    logic [15:0] sense_line_pair = 16'h0;
    logic go = 1'h0, wr = 1'h0, slow = 1'h0, busy;
    logic [15:0] wdata = 16'h0, data_bit_line_n_i, word_n;
    logic [15:0] data_bit_line_n_o, data_bit_line_n_oe, inhibit_current_out;
    logic sense_strobe_in_n, inhibit_timing_in_n, write_cycle_flag;
    logic sense_strobe_low_byte, sense_strobe_high_byte;
    logic inhibit_pulse_low_byte, inhibit_pulse_high_byte;
    logic e_ss, e_ip, sel; // Expected strobe and pulse, our selection.
    logic [15:0] e_oe, e_inh; // Expected enables and inhibit drives.
    int bad_count = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'h5C;
    csil_top #(.INCR_INDEX(INCR), .HALF_INDEX(HALF)) u_csil_top (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .increment_select_n(increment_select_n),
        .half_stack_enable(half_stack_enable),
        .sense_strobe_in_n(sense_strobe_in_n),
        .inhibit_timing_in_n(inhibit_timing_in_n),
        .write_cycle_flag(write_cycle_flag),
        .sense_line_pair(sense_line_pair),
        .data_bit_line_n_i(data_bit_line_n_i),
        .data_bit_line_n_o(data_bit_line_n_o),
        .data_bit_line_n_oe(data_bit_line_n_oe),
        .sense_strobe_low_byte(sense_strobe_low_byte),
        .sense_strobe_high_byte(sense_strobe_high_byte),
        .inhibit_pulse_low_byte(inhibit_pulse_low_byte),
        .inhibit_pulse_high_byte(inhibit_pulse_high_byte),
        .inhibit_current_out(inhibit_current_out));
    csil_mem_model u_csil_mem_model (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .go(go), .wr(wr),
        .slow(slow), .wdata(wdata), .line_oe(data_bit_line_n_oe),
        .sense_strobe_in_n(sense_strobe_in_n),
        .inhibit_timing_in_n(inhibit_timing_in_n),
        .write_cycle_flag(write_cycle_flag), .line_n(data_bit_line_n_i),
        .word_n(word_n), .busy(busy));
    // Only one low select, on our index, with our half enabled.
    assign sel = increment_select_n == (4'hF ^ (4'h1 << INCR)) &&
        half_stack_enable[HALF] === 1'h1;
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // Xorshift source for the random stimulus.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Compare at mid-cycle, then step the model from the settled inputs.
    always @(negedge clk_sys) begin
        if (sys_rst) begin
            {e_ss, e_ip, e_oe, e_inh} = '0;
        end else begin
            chk("strobe_low", 16'(e_ss), 16'(sense_strobe_low_byte));
            chk("strobe_high", 16'(e_ss), 16'(sense_strobe_high_byte));
            chk("pulse_low", 16'(e_ip), 16'(inhibit_pulse_low_byte));
            chk("pulse_high", 16'(e_ip), 16'(inhibit_pulse_high_byte));
            chk("line_oe", e_oe, data_bit_line_n_oe);
            chk("line_o", 16'h0, data_bit_line_n_o);
            chk("inhibit", e_inh, inhibit_current_out);
            e_oe = e_ss ? sense_line_pair : 16'h0;
            e_inh = e_ip ? data_bit_line_n_i : 16'h0;
            e_ss = sel && !sense_strobe_in_n;
            e_ip = sel && !inhibit_timing_in_n;
        end
    end
    // Random selection; a hit forces our increment and half stack.
    task automatic pick(input logic hit);
        logic [31:0] r;
        r = rnd();
        @(posedge clk_sys);
        #1;
        increment_select_n = r[7] ? r[3:0] : 4'hF ^ (4'h1 << r[1:0]);
        if (hit) increment_select_n = 4'hF ^ (4'h1 << INCR);
        half_stack_enable = hit ? {1'h1, r[6]} : r[5:4];
        sense_line_pair = r[31:16];
        wdata = r[23:8];
    endtask
    // One memory cycle; a read must leave the sensed ones in the register.
    task automatic run_op(input logic w, input logic s);
        int n;
        @(posedge clk_sys);
        #1;
        {wr, slow, go} = {w, s, 1'h1};
        @(posedge clk_sys);
        #1;
        go = 1'h0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (busy === 1'h1 && n < 40);
        if (n >= 40) chk("busy", 16'h0, 16'h1);
        if (!w) chk("word", sel ? sense_line_pair : 16'h0, ~word_n);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdog against a hung sequence.
    initial begin
        repeat (3000) @(posedge clk_sys);
        chk("watchdog", 16'h0, 16'h1);
        close_out();
    end
    // Main sequence, with a second reset in mid-run.
    initial begin
        repeat (6) @(posedge clk_sys);
        #1 sys_rst = 1'h0;
        for (int i = 0; i < 32; i++) begin
            pick(!i[0]);
            run_op(i[1], i[2]);
        end
        @(posedge clk_sys);
        #1 sys_rst = 1'h1;
        repeat (2) @(posedge clk_sys);
        #1 sys_rst = 1'h0;
        pick(1'h1);
        run_op(1'h0, 1'h1);
        close_out();
    end
endmodule
`default_nettype wire
